// file: pkg/rssm_params.svh
`ifndef RSSM_PARAMS_SVH
`define RSSM_PARAMS_SVH

// Register map
`define RSSM_CSR_ADDR       8'h00
`define RSSM_ADDR_W         8

// Control/status field positions
`define RSSM_BIT_WDG_FLAG   0
`define RSSM_BIT_UV_FLAG    4
`define RSSM_BIT_WARN_FLAG  5
`define RSSM_BIT_WARN_EN    6
`define RSSM_CSR_RESET      8'h00

// Timing
`define RSSM_CLK_MHZ        40
`define RSSM_WDG_PULSE_NS   200
`define RSSM_WDG_PULSE_CYC  ((`RSSM_WDG_PULSE_NS * `RSSM_CLK_MHZ + 999) / 1000)
`define RSSM_DLY_SHORT_CYC  13'h0100
`define RSSM_DLY_LONG_CYC   13'h1000
`define RSSM_FETCH_CYC      2'h2
`define RSSM_BLANK_CYC      3'h4

`endif

// file: pkg/rssm_pkg.sv
package rssm_pkg;

  typedef enum logic [3:0] {
    st_active = 4'h1,
    st_delay  = 4'h2,
    st_fetch  = 4'h4,
    st_run    = 4'h8
  } rssm_state_type;

  typedef logic [7:0]  rssm_csr_type;
  typedef logic [31:0] rssm_word_type;

endpackage

// file: design/rssm_top.sv
`timescale 1ns/1ps
`include "rssm_params.svh"
module rssm_top (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire rssm_pkg::rssm_word_type pwdata,
  output rssm_pkg::rssm_word_type   prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 reset_pin_in,
  output logic                      reset_pin_out,
  output logic                      reset_pin_oe_n,
  input  wire logic                 undervolt_comp,
  input  wire logic                 supply_warn_comp,
  input  wire logic                 undervolt_option_en,
  input  wire logic                 long_delay_sel,
  input  wire logic                 watchdog_underflow,
  input  wire logic                 halt_mode,
  input  wire logic                 wait_mode,
  input  wire logic                 cpu_irq_masked,
  input  wire logic                 irq_ack,
  output logic                      sys_reset,
  output logic                      vector_fetch,
  output logic                      supply_warn_irq,
  output logic                      wake_from_wait
);
  import rssm_pkg::*;

  localparam logic [3:0] WDG_CYC = 4'(`RSSM_WDG_PULSE_CYC);

  // Three-stage synchronisers: pin, undervoltage, warning comparator
  logic [2:0] raw_in;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] filt_ff;
  logic [2:0] nxt_filt;

  assign raw_in = {supply_warn_comp, undervolt_comp, reset_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Idle levels: pin high, comparators reporting good supply
      localparam logic IDLE = (gi == 0) ? 1'b1 : 1'b0;
      assign nxt_filt[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : filt_ff[gi];
      always_ff @(posedge clock) begin
        if (rst) begin
          sync1_ff[gi] <= IDLE;
          sync2_ff[gi] <= IDLE;
          sync3_ff[gi] <= IDLE;
          filt_ff[gi]  <= IDLE;
        end else begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          filt_ff[gi]  <= nxt_filt[gi];
        end
      end
    end
  endgenerate

  wire pin_low_filt = ~filt_ff[0];
  wire uv_filt      = filt_ff[1];
  wire warn_filt    = filt_ff[2];

  // State and counters
  rssm_state_type state_ff;
  rssm_state_type nxt_state;
  logic [12:0]    dly_cnt_ff;
  logic [12:0]    nxt_dly_cnt;
  logic [1:0]     fetch_cnt_ff;
  logic [1:0]     nxt_fetch_cnt;
  logic [3:0]     wdg_cnt_ff;
  logic [3:0]     nxt_wdg_cnt;
  logic [2:0]     blank_ff;
  logic [2:0]     nxt_blank;
  logic           drive_ff;
  logic           nxt_drive;

  // Register bits
  logic uv_flag_ff;
  logic wdg_flag_ff;
  logic warn_flag_ff;
  logic warn_en_ff;
  logic pending_ff;
  logic nxt_uv_flag;
  logic nxt_wdg_flag;
  logic nxt_warn_flag;
  logic nxt_warn_en;
  logic nxt_pending;

  // Sources
  wire uv_active    = undervolt_option_en & uv_filt;
  wire wdg_busy     = (wdg_cnt_ff != 4'h0);
  // Our own drive and the pull-up recovery time would read as a pin reset
  wire ext_req      = pin_low_filt & ~drive_ff & (blank_ff == 3'h0);
  wire ext_async    = ~reset_pin_in & ~drive_ff;
  wire any_src      = ext_req | uv_active | wdg_busy | watchdog_underflow;
  wire in_reset     = (state_ff == st_active) | (state_ff == st_delay);
  wire running      = (state_ff == st_run);
  wire frozen       = halt_mode & running;
  wire [12:0] dly_load = (long_delay_sel ? `RSSM_DLY_LONG_CYC : `RSSM_DLY_SHORT_CYC)
                         - 13'h0001;

  // Sequencer
  always_comb begin
    nxt_state     = state_ff;
    nxt_dly_cnt   = dly_cnt_ff;
    nxt_fetch_cnt = fetch_cnt_ff;
    case (state_ff)
      st_active: begin
        if (!any_src) begin
          nxt_state   = st_delay;
          nxt_dly_cnt = dly_load;
        end
      end
      st_delay: begin
        if (any_src) begin
          nxt_state = st_active;
        end else if (dly_cnt_ff == 13'h0000) begin
          nxt_state     = st_fetch;
          nxt_fetch_cnt = `RSSM_FETCH_CYC - 2'h1;
        end else begin
          nxt_dly_cnt = dly_cnt_ff - 13'h0001;
        end
      end
      st_fetch: begin
        if (any_src) begin
          nxt_state = st_active;
        end else if (fetch_cnt_ff == 2'h0) begin
          nxt_state = st_run;
        end else begin
          nxt_fetch_cnt = fetch_cnt_ff - 2'h1;
        end
      end
      st_run: begin
        if (any_src) begin
          nxt_state = st_active;
        end
      end
      default: begin
        nxt_state = st_active;
      end
    endcase
  end

  assign nxt_wdg_cnt = watchdog_underflow ? WDG_CYC :
                       (wdg_busy ? wdg_cnt_ff - 4'h1 : 4'h0);
  // Pin held low by undervoltage, watchdog pulse and the whole delay phase
  // Busy term bridges the cycle between pulse end and delay entry
  assign nxt_drive   = uv_active | watchdog_underflow | (nxt_wdg_cnt != 4'h0)
                       | wdg_busy | (nxt_state == st_delay);
  assign nxt_blank   = drive_ff ? `RSSM_BLANK_CYC :
                       ((blank_ff != 3'h0) ? blank_ff - 3'h1 : 3'h0);

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff     <= st_active;
      dly_cnt_ff   <= 13'h0000;
      fetch_cnt_ff <= 2'h0;
      wdg_cnt_ff   <= 4'h0;
      blank_ff     <= 3'h0;
      drive_ff     <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      dly_cnt_ff   <= nxt_dly_cnt;
      fetch_cnt_ff <= nxt_fetch_cnt;
      wdg_cnt_ff   <= nxt_wdg_cnt;
      blank_ff     <= nxt_blank;
      drive_ff     <= nxt_drive;
    end
  end

  // Pin reset leaks straight through so halt with no clock still resets
  assign sys_reset      = in_reset | ext_async;
  assign vector_fetch   = (state_ff == st_fetch);
  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = ~drive_ff;

  // APB decode
  wire  addr_hit  = (paddr == `RSSM_CSR_ADDR);
  wire  setup_ph  = psel & ~penable;
  wire  wr_acc    = psel & penable & pwrite & pready & addr_hit & ~frozen;
  wire  clr_uv    = wr_acc & ~pwdata[`RSSM_BIT_UV_FLAG];
  wire  clr_wdg   = wr_acc & ~pwdata[`RSSM_BIT_WDG_FLAG];
  wire  en_rise   = nxt_warn_en & ~warn_en_ff;
  wire  warn_upd  = undervolt_option_en & ~frozen;
  wire  toggle    = warn_upd & (warn_filt != warn_flag_ff);
  wire  set_pend  = running & ~halt_mode &
                    ((toggle & warn_en_ff) | (en_rise & warn_flag_ff));
  rssm_csr_type csr_rd;

  assign pready  = psel & penable;
  // Reserved bits and unused upper bits read zero
  assign csr_rd  = {1'b0, warn_en_ff, warn_flag_ff, uv_flag_ff, 3'b000, wdg_flag_ff};

  // Set wins over a software clear in the same cycle
  assign nxt_uv_flag   = uv_active | (uv_flag_ff & ~clr_uv);
  assign nxt_wdg_flag  = watchdog_underflow |
                         (wdg_flag_ff & ~clr_wdg & ~uv_active);
  assign nxt_warn_flag = warn_upd ? warn_filt : warn_flag_ff;
  assign nxt_warn_en   = in_reset ? 1'b0 :
                         (wr_acc ? pwdata[`RSSM_BIT_WARN_EN] : warn_en_ff);
  assign nxt_pending   = ~in_reset & ~uv_active &
                         (set_pend | (pending_ff & ~irq_ack));

  always_ff @(posedge clock) begin
    if (rst) begin
      uv_flag_ff   <= 1'(`RSSM_CSR_RESET >> `RSSM_BIT_UV_FLAG);
      wdg_flag_ff  <= 1'b0;
      warn_flag_ff <= 1'b0;
      warn_en_ff   <= 1'b0;
      pending_ff   <= 1'b0;
    end else begin
      uv_flag_ff   <= nxt_uv_flag;
      wdg_flag_ff  <= nxt_wdg_flag;
      warn_flag_ff <= nxt_warn_flag;
      warn_en_ff   <= nxt_warn_en;
      pending_ff   <= nxt_pending;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= addr_hit ? {24'h00_0000, csr_rd} : 32'h0000_0000;
      pslverr <= ~addr_hit;
    end
  end

  assign supply_warn_irq = pending_ff & warn_en_ff & ~cpu_irq_masked;
  // Halt gives no wake path; wait mode does
  assign wake_from_wait  = wait_mode & pending_ff & warn_en_ff;

  pin_async_a: assert property (@(posedge clock) disable iff (rst)
    (!reset_pin_in && !drive_ff) |-> sys_reset)
    else $error("pin low without internal reset");

  uv_pin_a: assert property (@(posedge clock) disable iff (rst)
    uv_active |=> !reset_pin_oe_n)
    else $error("undervoltage reset not driving pin");

  wdg_pulse_a: assert property (@(posedge clock) disable iff (rst)
    watchdog_underflow |=> (!reset_pin_oe_n) [*8])
    else $error("watchdog pin pulse too short");

  uv_off_a: assert property (@(posedge clock) disable iff (rst)
    !undervolt_option_en |=> !$rose(uv_flag_ff))
    else $error("undervoltage flag set with option off");

  warn_hold_a: assert property (@(posedge clock) disable iff (rst)
    !undervolt_option_en |=> $stable(warn_flag_ff) && !$rose(pending_ff))
    else $error("warning monitor active with option off");

  warn_live_a: assert property (@(posedge clock) disable iff (rst)
    (undervolt_option_en && !frozen) |=> warn_flag_ff == $past(warn_filt))
    else $error("warning flag not tracking comparator");

  toggle_irq_a: assert property (@(posedge clock) disable iff (rst)
    (running && !halt_mode && warn_en_ff && toggle && !uv_active && !any_src)
    |=> pending_ff)
    else $error("flag toggle raised no request");

  ack_clear_a: assert property (@(posedge clock) disable iff (rst)
    (irq_ack && !set_pend) |=> !pending_ff)
    else $error("pending request survived service entry");

  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    supply_warn_irq |-> (warn_en_ff && !cpu_irq_masked))
    else $error("interrupt not gated by enable and mask");

  uv_keep_a: assert property (@(posedge clock) disable iff (rst)
    (uv_flag_ff && !clr_uv) |=> uv_flag_ff)
    else $error("undervoltage flag lost");

  wdg_clr_a: assert property (@(posedge clock) disable iff (rst)
    (uv_active && !watchdog_underflow) |=> !wdg_flag_ff)
    else $error("watchdog flag kept through undervoltage reset");

  fetch_two_a: assert property (@(posedge clock) disable iff (rst)
    (state_ff == st_delay && dly_cnt_ff == 13'h0000 && !any_src) |=> vector_fetch)
    else $error("no vector fetch after delay");

  boot_quiet_a: assert property (@(posedge clock) disable iff (rst)
    !running |=> !$rose(pending_ff))
    else $error("warning request raised during reset sequence");

  en_rise_a: assert property (@(posedge clock) disable iff (rst)
    (running && !halt_mode && warn_flag_ff && !warn_en_ff && wr_acc
     && pwdata[`RSSM_BIT_WARN_EN] && !any_src) |=> pending_ff)
    else $error("enable with flag set raised no request");

  halt_freeze_a: assert property (@(posedge clock) disable iff (rst)
    frozen |=> $stable(warn_en_ff) && $stable(warn_flag_ff))
    else $error("register changed in halt");

  uv_set_a: assert property (@(posedge clock) disable iff (rst)
    uv_active |=> uv_flag_ff)
    else $error("undervoltage flag not set");

  wdg_set_a: assert property (@(posedge clock) disable iff (rst)
    watchdog_underflow |=> wdg_flag_ff)
    else $error("watchdog flag not set");

  rsvd_zero_a: assert property (@(posedge clock) disable iff (rst)
    (prdata[31:7] == 25'h0000000) && (prdata[3:1] == 3'h0))
    else $error("reserved bits read nonzero");

  en_reset_a: assert property (@(posedge clock) disable iff (rst)
    in_reset |=> !warn_en_ff)
    else $error("enable survived reset");

  merge_a: assert property (@(posedge clock) disable iff (rst)
    any_src |=> sys_reset)
    else $error("reset source gave no internal reset");

  irq_seen_c: cover property (@(posedge clock) disable iff (rst) $rose(supply_warn_irq));
  uv_reset_c: cover property (@(posedge clock) disable iff (rst) $rose(uv_flag_ff));
  wake_c: cover property (@(posedge clock) disable iff (rst) $rose(wake_from_wait));
  boot_c: cover property (@(posedge clock) disable iff (rst)
    vector_fetch ##1 vector_fetch ##1 running);
  wdg_reset_c: cover property (@(posedge clock) disable iff (rst) $rose(wdg_flag_ff));

endmodule

// file: verification/rssm_far_side.sv
`timescale 1ns/1ps
module rssm_far_side (
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe_n,
  input  wire logic ext_pull_low,
  input  wire logic supply_low,
  input  wire logic supply_warn,
  output logic      reset_pin_in,
  output logic      undervolt_comp,
  output logic      supply_warn_comp
);
  // Weak pull-up wins only while nobody pulls the shared pin down
  assign reset_pin_in     = !(ext_pull_low || (!reset_pin_oe_n && !reset_pin_out));
  // Hysteresis lives in the analog comparators, so plain levels here
  assign undervolt_comp   = supply_low;
  assign supply_warn_comp = supply_warn;
endmodule

// file: verification/reset_source_and_supply_monitor_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module reset_source_and_supply_monitor_test;
  import rssm_pkg::*;
  logic          clock, rst, psel, penable, pwrite, clk_en, err;
  logic [7:0]    paddr, q;
  rssm_word_type pwdata, prdata;
  logic          pready, pslverr, pin_in, pin_out, oe_n, uv, warn;
  logic          uv_opt, long_sel, wdg_uf, halt, waitm, masked, ack;
  logic          sys_reset, vfetch, irq, wake, ext_low, sup_low, sup_warn;
  int            bad_count, cmp_count, n, f;

  rssm_top u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_in(pin_in),
    .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .undervolt_comp(uv),
    .supply_warn_comp(warn), .undervolt_option_en(uv_opt), .long_delay_sel(long_sel),
    .watchdog_underflow(wdg_uf), .halt_mode(halt), .wait_mode(waitm),
    .cpu_irq_masked(masked), .irq_ack(ack), .sys_reset(sys_reset),
    .vector_fetch(vfetch), .supply_warn_irq(irq), .wake_from_wait(wake));

  rssm_far_side u_far (.reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .ext_pull_low(ext_low), .supply_low(sup_low), .supply_warn(sup_warn),
    .reset_pin_in(pin_in), .undervolt_comp(uv), .supply_warn_comp(warn));

  // Gated so the asynchronous pin path can be seen with no clock at all
  initial begin
    clock = 1'b0;
    forever #12.5 if (clk_en) clock = ~clock;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q       = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic low_run();
    int k;
    n = 0;
    k = 0;
    while (oe_n !== 1'b0 && k < 60) begin
      @(posedge clock);
      k++;
    end
    while (oe_n === 1'b0 && n < 6000) begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    f = (vfetch === 1'b1) ? 1 : 0;
    while ((sys_reset !== 1'b0 || vfetch !== 1'b0) && k < 6000) begin
      @(posedge clock);
      if (vfetch === 1'b1) f++;
      k++;
    end
  endtask

  task automatic do_ack();
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    bad_count++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, wdg_uf, halt, waitm} = '0;
    {masked, ack, ext_low, sup_low, sup_warn, long_sel, err, q} = '0;
    {bad_count, cmp_count, n, f} = '0;
    clk_en = 1'b1;
    uv_opt = 1'b1;
    rst    = 1'b1;
    do_reset();
    low_run();
    `CHK("short delay", 1'b1, n >= 256 && n <= 257)
    wait_run();
    `CHK("fetch cycles", 2, f)
    apb(1'b0, 8'h00, 8'h00);
    `CHK("csr reset", 8'h00, q)
    apb(1'b0, 8'h04, 8'h00);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 8'h00, 8'hff);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("csr write", 8'h40, q)
    end_test("registers");
    sup_warn <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("irq fall", 1'b1, irq)
    apb(1'b0, 8'h00, 8'h00);
    `CHK("live flag", 8'h60, q)
    do_ack();
    `CHK("irq ack", 1'b0, irq)
    masked   <= 1'b1;
    waitm    <= 1'b1;
    sup_warn <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    `CHK("wake", 1'b1, wake)
    masked <= 1'b0;
    waitm  <= 1'b0;
    @(posedge clock);
    `CHK("irq rise", 1'b1, irq)
    do_ack();
    apb(1'b1, 8'h00, 8'h00);
    sup_warn <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, 8'h00, 8'h40);
    @(posedge clock);
    `CHK("irq enable", 1'b1, irq)
    do_ack();
    end_test("interrupt");
    halt <= 1'b1;
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("halt frozen", 8'h60, q)
    sup_warn <= 1'b0;
    repeat (8) @(posedge clock);
    sup_warn <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("halt irq", 1'b0, irq)
    halt <= 1'b0;
    apb(1'b1, 8'h00, 8'h00);
    sup_warn <= 1'b0;
    end_test("halt");
    wdg_uf <= 1'b1;
    @(posedge clock);
    wdg_uf <= 1'b0;
    low_run();
    `CHK("wdg pulse", 1'b1, n >= 264)
    wait_run();
    apb(1'b0, 8'h00, 8'h00);
    `CHK("wdg cause", 8'h01, q)
    sup_low <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("uv pin", 1'b0, oe_n)
    `CHK("uv reset", 1'b1, sys_reset)
    sup_low <= 1'b0;
    wait_run();
    apb(1'b0, 8'h00, 8'h00);
    `CHK("uv cause", 8'h10, q)
    end_test("causes");
    halt   <= 1'b1;
    @(posedge clock);
    clk_en = 1'b0;
    #40 ext_low = 1'b1;
    #40 `CHK("pin async", 1'b1, sys_reset)
    clk_en = 1'b1;
    repeat (10) @(posedge clock);
    ext_low <= 1'b0;
    halt    <= 1'b0;
    wait_run();
    apb(1'b0, 8'h00, 8'h00);
    `CHK("uv kept", 8'h10, q)
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("uv cleared", 8'h00, q)
    uv_opt  <= 1'b0;
    sup_low <= 1'b1;
    repeat (20) @(posedge clock);
    `CHK("option off", 1'b0, sys_reset)
    sup_warn <= 1'b1;
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("warn off", 8'h00, q)
    {sup_low, sup_warn} <= 2'b00;
    uv_opt   <= 1'b1;
    long_sel <= 1'b1;
    end_test("pin and option");
    do_reset();
    low_run();
    `CHK("long delay", 1'b1, n >= 4096 && n <= 4097)
    wait_run();
    end_test("long delay");
    final_report();
  end
endmodule
